// *** verilog/ccp_cfg.svh ***
// Purpose: register offsets, field positions, reset values and mode codes
// Assumes: 12-bit register address, 8-bit register data
// Notes  : definitions only
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define ADDR_ASD_CTRL    12'hfbe
`define ADDR_UNIT_CTRL   12'hfba
`define ADDR_CMP_LO      12'hfbb
`define ADDR_CMP_HI      12'hfbc
`define ADDR_TB_SEL      12'hfb0
`define ADDR_EVT_STATUS  12'hfb1
`define ADDR_RESTART     12'hfb2

// ****************************************************************
// reset values
// ****************************************************************
`define RST_BYTE         8'h00
`define RST_WORD         16'h0000
`define RST_NIB          4'h0

// ****************************************************************
// auto-shutdown control fields
// ****************************************************************
`define ASD_FLAG_BIT     7
`define ASD_SRC_HI       6
`define ASD_SRC_LO       4
`define PSS_AC_HI        3
`define PSS_AC_LO        2
`define PSS_BD_HI        1
`define PSS_BD_LO        0
`define PSS_TRI_BIT      1
`define PSS_LVL_BIT      0

// ****************************************************************
// event status fields
// ****************************************************************
`define EVT_FLAG_BIT     0
`define EVT_IRQEN_BIT    1

// ****************************************************************
// unit mode select codes and capture prescaler limits
// ****************************************************************
`define MODE_OFF         4'h0
`define MODE_TOGGLE      4'h2
`define MODE_CAP_FALL    4'h4
`define MODE_CAP_RISE    4'h5
`define MODE_CAP_RISE4   4'h6
`define MODE_CAP_RISE16  4'h7
`define MODE_CMP_HIGH    4'h8
`define MODE_CMP_LOW     4'h9
`define MODE_CMP_FLAG    4'ha
`define MODE_CMP_TRIG    4'hb
`define PRESC_LIM_1      4'h0
`define PRESC_LIM_4      4'h3
`define PRESC_LIM_16     4'hf

`endif

// *** verilog/ccp_pkg.sv ***
// Purpose: shared types of the capture/compare unit
// Assumes: constants live in ccp_cfg.svh
// Notes  : types only
package ccp_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
  typedef logic [3:0]  mode_t;
  typedef enum logic [1:0] {
    PWM_RUN,
    PWM_SHUT,
    PWM_WAIT_PERIOD
  } pwm_state_t;
endpackage

// *** verilog/sync2.sv ***
// Purpose: two-flop synchroniser for inputs from outside mclk
// Assumes: synchronous active-low reset
// Notes  : first stage is read by the second stage only
`timescale 1ns/10ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // two stages to let metastability settle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// *** verilog/capture_compare_autoshutdown.sv ***
// Purpose: capture/compare unit with compare trigger and pwm auto-shutdown
// Assumes: pins, comparators and fault pin are asynchronous to mclk;
//          timebases, port latch and pwm levels come from mclk logic
// Notes  : pwm pin outputs are forced combinationally from the shutdown
//          condition so the force does not wait for a register stage
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "ccp_cfg.svh"

module capture_compare_autoshutdown (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        capture_pin,
  input  wire logic [15:0] timebase_a,
  input  wire logic [15:0] timebase_b,
  input  wire logic        port_latch,
  input  wire logic        adc_enabled,
  input  wire logic        comparator_one_out,
  input  wire logic        comparator_two_out,
  input  wire logic        fault_input_pin,
  input  wire logic        pwm_in_a,
  input  wire logic        pwm_in_b,
  input  wire logic        pwm_in_c,
  input  wire logic        pwm_in_d,
  input  wire logic [3:0]  pwm_pin_en,
  input  wire logic        pwm_period_start,
  output logic             compare_output_pin,
  output logic             timebase_a_reset,
  output logic             timebase_b_reset,
  output logic             adc_start,
  output logic             unit_event_irq,
  output logic             pwm_out_a,
  output logic             pwm_out_b,
  output logic             pwm_out_c,
  output logic             pwm_out_d,
  output logic             pwm_oe_n_a,
  output logic             pwm_oe_n_b,
  output logic             pwm_oe_n_c,
  output logic             pwm_oe_n_d
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [3:0]             sync_v;
  logic                   cap_s;
  logic                   cmp1_s;
  logic                   cmp2_s;
  logic                   flt_s;
  ccp_pkg::byte_t         unit_ctrl_q;
  ccp_pkg::mode_t         unit_mode_select;
  ccp_pkg::word_t         compare_value_pair;
  logic                   tb_sel_q;
  logic                   unit_event_flag;
  logic                   unit_event_irq_enable;
  logic                   auto_restart_q;
  logic                   shutdown_active_flag;
  logic [2:0]             shutdown_source_select;
  logic [1:0]             pair_ac_shutdown_state;
  logic [1:0]             pair_bd_shutdown_state;
  logic                   wr_unit;
  logic                   wr_lo;
  logic                   wr_hi;
  logic                   wr_tb;
  logic                   wr_evt;
  logic                   wr_rst;
  logic                   wr_asd;
  logic                   is_capture;
  logic                   is_compare;
  logic                   pin_drive;
  ccp_pkg::word_t         tb_cur;
  logic                   match_now;
  logic                   match_q;
  logic                   match_pulse;
  logic                   trig;
  logic                   cmp_latch_q;
  logic                   cmp_latch_d;
  logic                   cap_prev_q;
  logic                   edge_hit;
  logic [3:0]             presc_cnt_q;
  logic [3:0]             presc_lim;
  logic                   capture_evt;
  logic                   shut_cond;
  logic                   forced;
  ccp_pkg::pwm_state_t    pwm_state_q;
  logic [3:0]             pwm_v;
  logic [3:0]             pin_lvl;
  logic [3:0]             pin_oe_n;
  ccp_pkg::byte_t         rd_mux;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  sync2 #(.WIDTH(4)) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({capture_pin, comparator_two_out, comparator_one_out, fault_input_pin}),
    .sync_out (sync_v)
  );
  assign cap_s  = sync_v[3];
  assign cmp2_s = sync_v[2];
  assign cmp1_s = sync_v[1];
  assign flt_s  = sync_v[0];

  // ****************************************************************
  // register decode
  // ****************************************************************
  assign wr_unit = reg_wr && (reg_addr == `ADDR_UNIT_CTRL);
  assign wr_lo   = reg_wr && (reg_addr == `ADDR_CMP_LO);
  assign wr_hi   = reg_wr && (reg_addr == `ADDR_CMP_HI);
  assign wr_tb   = reg_wr && (reg_addr == `ADDR_TB_SEL);
  assign wr_evt  = reg_wr && (reg_addr == `ADDR_EVT_STATUS);
  assign wr_rst  = reg_wr && (reg_addr == `ADDR_RESTART);
  assign wr_asd  = reg_wr && (reg_addr == `ADDR_ASD_CTRL);

  // plain control registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      unit_ctrl_q           <= `RST_BYTE;
      tb_sel_q              <= 1'b0;
      unit_event_irq_enable <= 1'b0;
      auto_restart_q        <= 1'b0;
    end else begin
      if (wr_unit) begin
        unit_ctrl_q <= reg_wdata;
      end
      if (wr_tb) begin
        tb_sel_q <= reg_wdata[0];
      end
      if (wr_evt) begin
        unit_event_irq_enable <= reg_wdata[`EVT_IRQEN_BIT];
      end
      if (wr_rst) begin
        auto_restart_q <= reg_wdata[0];
      end
    end
  end

  // ****************************************************************
  // mode decode and timebase selection
  // ****************************************************************
  assign unit_mode_select = unit_ctrl_q[3:0];
  assign is_capture = (unit_mode_select[3:2] == 2'b01);
  assign is_compare = (unit_mode_select[3:2] == 2'b10) || (unit_mode_select == `MODE_TOGGLE);
  assign pin_drive  = (unit_mode_select == `MODE_CMP_HIGH) ||
                      (unit_mode_select == `MODE_CMP_LOW)  ||
                      (unit_mode_select == `MODE_TOGGLE);
  assign tb_cur     = tb_sel_q ? timebase_b : timebase_a;

  // ****************************************************************
  // compare
  // ****************************************************************
  // only the first cycle of equality acts, so a stalled timer fires once
  assign match_now   = is_compare && (tb_cur == compare_value_pair);
  assign match_pulse = match_now && !match_q;
  assign trig        = match_pulse && (unit_mode_select == `MODE_CMP_TRIG);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      match_q <= 1'b0;
    end else begin
      match_q <= match_now;
    end
  end

  // next value of the compare output latch
  always_comb begin
    cmp_latch_d = cmp_latch_q;
    if (wr_unit && (reg_wdata == `RST_BYTE)) begin
      cmp_latch_d = 1'b0;
    end else if (match_pulse) begin
      case (unit_mode_select)
        `MODE_CMP_HIGH: cmp_latch_d = 1'b1;
        `MODE_CMP_LOW:  cmp_latch_d = 1'b0;
        `MODE_TOGGLE:   cmp_latch_d = !cmp_latch_q;
        default:        cmp_latch_d = cmp_latch_q;
      endcase
    end
  end

  // latch and pin register; the pin follows the port latch when not driven
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmp_latch_q        <= 1'b0;
      compare_output_pin <= 1'b0;
    end else begin
      cmp_latch_q        <= cmp_latch_d;
      compare_output_pin <= pin_drive ? cmp_latch_d : port_latch;
    end
  end

  // trigger pulses to the timers and the converter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timebase_a_reset <= 1'b0;
      timebase_b_reset <= 1'b0;
      adc_start        <= 1'b0;
    end else begin
      timebase_a_reset <= trig && !tb_sel_q;
      timebase_b_reset <= trig && tb_sel_q;
      adc_start        <= trig && adc_enabled;
    end
  end

  // ****************************************************************
  // capture with prescaler
  // ****************************************************************
  always_comb begin
    case (unit_mode_select)
      `MODE_CAP_RISE4:  presc_lim = `PRESC_LIM_4;
      `MODE_CAP_RISE16: presc_lim = `PRESC_LIM_16;
      default:          presc_lim = `PRESC_LIM_1;
    endcase
  end

  assign edge_hit = (unit_mode_select == `MODE_CAP_FALL) ? (cap_prev_q && !cap_s)
                                                         : (!cap_prev_q && cap_s);
  // a count left above a lowered limit fires on the next edge
  assign capture_evt = is_capture && edge_hit && (presc_cnt_q >= presc_lim);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cap_prev_q  <= 1'b0;
      presc_cnt_q <= `RST_NIB;
    end else begin
      cap_prev_q <= cap_s;
      if (!is_capture) begin
        presc_cnt_q <= `RST_NIB;
      end else if (capture_evt) begin
        presc_cnt_q <= `RST_NIB;
      end else if (edge_hit) begin
        presc_cnt_q <= presc_cnt_q + 4'h1;
      end
    end
  end

  // value pair: a capture wins over a software write in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      compare_value_pair <= `RST_WORD;
    end else if (capture_evt) begin
      compare_value_pair <= tb_cur;
    end else if (wr_lo) begin
      compare_value_pair[7:0] <= reg_wdata;
    end else if (wr_hi) begin
      compare_value_pair[15:8] <= reg_wdata;
    end
  end

  // event flag: hardware set wins over a software clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      unit_event_flag <= 1'b0;
      unit_event_irq  <= 1'b0;
    end else begin
      if (match_pulse || capture_evt) begin
        unit_event_flag <= 1'b1;
      end else if (wr_evt) begin
        unit_event_flag <= reg_wdata[`EVT_FLAG_BIT];
      end
      unit_event_irq <= unit_event_flag && unit_event_irq_enable;
    end
  end

  // ****************************************************************
  // auto-shutdown
  // ****************************************************************
  // fault pin is active low; each source bit adds one input
  assign shut_cond = |(shutdown_source_select & {!flt_s, cmp2_s, cmp1_s});

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shutdown_active_flag   <= 1'b0;
      shutdown_source_select <= 3'h0;
      pair_ac_shutdown_state <= 2'h0;
      pair_bd_shutdown_state <= 2'h0;
    end else begin
      if (wr_asd) begin
        shutdown_source_select <= reg_wdata[`ASD_SRC_HI:`ASD_SRC_LO];
        pair_ac_shutdown_state <= reg_wdata[`PSS_AC_HI:`PSS_AC_LO];
        pair_bd_shutdown_state <= reg_wdata[`PSS_BD_HI:`PSS_BD_LO];
      end
      if (shut_cond) begin
        shutdown_active_flag <= 1'b1;
      end else if (auto_restart_q) begin
        shutdown_active_flag <= 1'b0;
      end else if (wr_asd) begin
        shutdown_active_flag <= reg_wdata[`ASD_FLAG_BIT];
      end
    end
  end

  // output state: restart waits for the flag to clear, then a period start
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pwm_state_q <= ccp_pkg::PWM_RUN;
    end else begin
      case (pwm_state_q)
        ccp_pkg::PWM_RUN: begin
          if (shut_cond || shutdown_active_flag) begin
            pwm_state_q <= ccp_pkg::PWM_SHUT;
          end
        end
        ccp_pkg::PWM_SHUT: begin
          if (!shut_cond && !shutdown_active_flag) begin
            pwm_state_q <= ccp_pkg::PWM_WAIT_PERIOD;
          end
        end
        ccp_pkg::PWM_WAIT_PERIOD: begin
          if (shut_cond || shutdown_active_flag) begin
            pwm_state_q <= ccp_pkg::PWM_SHUT;
          end else if (pwm_period_start) begin
            pwm_state_q <= ccp_pkg::PWM_RUN;
          end
        end
        default: pwm_state_q <= ccp_pkg::PWM_SHUT;
      endcase
    end
  end

  // force is taken straight from the condition, or from the state register when it is not in run
  assign forced = shut_cond || (pwm_state_q != ccp_pkg::PWM_RUN);
  assign pwm_v  = {pwm_in_d, pwm_in_c, pwm_in_b, pwm_in_a};

  // pins 0 and 2 are the A/C pair, 1 and 3 the B/D pair
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!pwm_pin_en[i]) begin
        pin_lvl[i]  = 1'b0;
        pin_oe_n[i] = 1'b1;
      end else if (!forced) begin
        pin_lvl[i]  = pwm_v[i];
        pin_oe_n[i] = 1'b0;
      end else if (i % 2 == 0) begin
        pin_lvl[i]  = pair_ac_shutdown_state[`PSS_LVL_BIT];
        pin_oe_n[i] = pair_ac_shutdown_state[`PSS_TRI_BIT];
      end else begin
        pin_lvl[i]  = pair_bd_shutdown_state[`PSS_LVL_BIT];
        pin_oe_n[i] = pair_bd_shutdown_state[`PSS_TRI_BIT];
      end
    end
  end

  assign pwm_out_a  = pin_lvl[0];
  assign pwm_out_b  = pin_lvl[1];
  assign pwm_out_c  = pin_lvl[2];
  assign pwm_out_d  = pin_lvl[3];
  assign pwm_oe_n_a = pin_oe_n[0];
  assign pwm_oe_n_b = pin_oe_n[1];
  assign pwm_oe_n_c = pin_oe_n[2];
  assign pwm_oe_n_d = pin_oe_n[3];

  // ****************************************************************
  // register read, data one cycle after the strobe only
  // ****************************************************************
  always_comb begin
    case (reg_addr)
      `ADDR_UNIT_CTRL:  rd_mux = unit_ctrl_q;
      `ADDR_CMP_LO:     rd_mux = compare_value_pair[7:0];
      `ADDR_CMP_HI:     rd_mux = compare_value_pair[15:8];
      `ADDR_TB_SEL:     rd_mux = {7'h00, tb_sel_q};
      `ADDR_EVT_STATUS: rd_mux = {6'h00, unit_event_irq_enable, unit_event_flag};
      `ADDR_RESTART:    rd_mux = {7'h00, auto_restart_q};
      `ADDR_ASD_CTRL:   rd_mux = {shutdown_active_flag, shutdown_source_select,
                                  pair_ac_shutdown_state, pair_bd_shutdown_state};
      default:          rd_mux = `RST_BYTE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= `RST_BYTE;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : `RST_BYTE;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_presc_clear;
    !is_capture |=> (presc_cnt_q == `RST_NIB);
  endproperty
  a_presc_clear: assert property (p_presc_clear)
    else $error("prescaler count not cleared outside capture");

  property p_match_flag;
    match_pulse |=> unit_event_flag &&
      (compare_output_pin == (pin_drive ? cmp_latch_q : $past(port_latch)));
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("flag and pin not updated together on match");

  property p_flag_only;
    (match_pulse && unit_mode_select == `MODE_CMP_FLAG && !wr_unit) |=> $stable(cmp_latch_q);
  endproperty
  a_flag_only: assert property (p_flag_only)
    else $error("flag-only match changed the output latch");

  property p_trig_reset;
    trig |=> (timebase_a_reset != timebase_b_reset) && (timebase_b_reset == $past(tb_sel_q));
  endproperty
  a_trig_reset: assert property (p_trig_reset)
    else $error("trigger did not reset the selected timebase");

  property p_adc_gate;
    adc_start |-> $past(trig) && $past(adc_enabled);
  endproperty
  a_adc_gate: assert property (p_adc_gate)
    else $error("conversion started without enabled converter");

  property p_clear_latch;
    (wr_unit && reg_wdata == `RST_BYTE) |=> !cmp_latch_q;
  endproperty
  a_clear_latch: assert property (p_clear_latch)
    else $error("zero write left compare latch high");

  property p_asd_hold;
    shut_cond |=> shutdown_active_flag && (pwm_state_q != ccp_pkg::PWM_RUN);
  endproperty
  a_asd_hold: assert property (p_asd_hold)
    else $error("shutdown condition did not set status and state");

  property p_force_pins;
    (shut_cond && pwm_pin_en[0]) |-> (pwm_oe_n_a == pair_ac_shutdown_state[1]) &&
      (pair_ac_shutdown_state[1] || pwm_out_a == pair_ac_shutdown_state[0]);
  endproperty
  a_force_pins: assert property (p_force_pins)
    else $error("pin A not in its shutdown state");

  property p_ignore_write;
    (shut_cond && wr_asd && !reg_wdata[`ASD_FLAG_BIT]) |=> shutdown_active_flag;
  endproperty
  a_ignore_write: assert property (p_ignore_write)
    else $error("status bit cleared while condition present");

  property p_restart_period;
    (pwm_state_q == ccp_pkg::PWM_RUN) && ($past(pwm_state_q) != ccp_pkg::PWM_RUN)
      |-> $past(pwm_period_start);
  endproperty
  a_restart_period: assert property (p_restart_period)
    else $error("pwm resumed away from a period start");

  property p_flag_sticky;
    (unit_event_flag && !wr_evt) |=> unit_event_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("event flag cleared without software");

endmodule

// *** test/timer_model.sv ***
// Purpose: far-side model: two timebases and a pwm period marker
// Assumes: timers count synchronously to mclk
// Notes  : a trigger pulse clears the matching timebase
`timescale 1ns/10ps
module timer_model (
  input  wire logic     mclk,
  input  wire logic     rst_n,
  input  wire logic     clr_a,
  input  wire logic     clr_b,
  output ccp_pkg::word_t tb_a,
  output ccp_pkg::word_t tb_b,
  output logic          period_start
);
  // synchronous timer mode only; async counting is left out on purpose
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tb_a <= 16'h0000;
      tb_b <= 16'h0000;
    end else begin
      tb_a <= clr_a ? 16'h0000 : tb_a + 16'h0001;
      tb_b <= clr_b ? 16'h0000 : tb_b + 16'h0001;
    end
  end
  // period start every 16 cycles of the second timebase
  assign period_start = (tb_b[3:0] == 4'hf);
endmodule

// *** test/capture_compare_autoshutdown_test.sv ***
// Purpose: self-checking bench for compare trigger and auto-shutdown
// Assumes: register map of ccp_cfg.svh
// Notes  : compare, capture prescaler and shutdown each have a scenario
`timescale 1ns/10ps
`include "ccp_cfg.svh"
module capture_compare_autoshutdown_test;
  logic mclk, rst_n, wr, rd, cap, latch, adc_en, c1, c2, fault;
  logic [11:0] addr;
  logic [7:0] wd, rdat, v;
  ccp_pkg::word_t ta, tb, t_cap;
  logic pin, ra, rb, adc_go, irq, ps, oa, ob, oc, od, na, nb, nc, nd;
  int fails = 0;
  int checks_done = 0;
  logic [3:0] en = 4'hf;
  timer_model i_timer_model (.mclk(mclk), .rst_n(rst_n), .clr_a(ra), .clr_b(rb),
    .tb_a(ta), .tb_b(tb), .period_start(ps));
  capture_compare_autoshutdown i_capture_compare_autoshutdown (.mclk(mclk),
    .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdat), .capture_pin(cap), .timebase_a(ta), .timebase_b(tb),
    .port_latch(latch), .adc_enabled(adc_en), .comparator_one_out(c1),
    .comparator_two_out(c2), .fault_input_pin(fault), .pwm_in_a(ta[0]),
    .pwm_in_b(ta[1]), .pwm_in_c(ta[2]), .pwm_in_d(ta[3]), .pwm_pin_en(en),
    .pwm_period_start(ps), .compare_output_pin(pin), .timebase_a_reset(ra),
    .timebase_b_reset(rb), .adc_start(adc_go), .unit_event_irq(irq),
    .pwm_out_a(oa), .pwm_out_b(ob), .pwm_out_c(oc), .pwm_out_d(od),
    .pwm_oe_n_a(na), .pwm_oe_n_b(nb), .pwm_oe_n_c(nc), .pwm_oe_n_d(nd));
  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // one-cycle strobes, launched just after a rising edge
  task automatic wr_reg(logic [11:0] a, logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [11:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdat;
  endtask
  // bounded wait so a dead output cannot hang the run
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 400 && s !== 1'b1; i++) @(negedge mclk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_compare();
    wr_reg(`ADDR_CMP_LO, 8'h80);
    wr_reg(`ADDR_CMP_HI, 8'h00);
    wr_reg(`ADDR_UNIT_CTRL, {4'h0, `MODE_CMP_TRIG});
    wait_hi(ra);
    chk("ra", ra, 1'b1);
    chk("adc", adc_go, 1'b1);
    @(negedge mclk);
    chk("ta", ta, 16'h0000);
    rd_reg(`ADDR_EVT_STATUS, v);
    chk("flag", v[0], 1'b1);
    @(posedge mclk);
    adc_en <= 1'b0;
    wait_hi(ra);
    chk("adc_off", adc_go, 1'b0);
    wr_reg(`ADDR_UNIT_CTRL, {4'h0, `MODE_CMP_HIGH});
    wait_hi(pin);
    chk("pin_hi", pin, 1'b1);
    chk("ra_idle", ra, 1'b0);
    // port latch high, so only a cleared compare latch shows low in toggle mode
    @(posedge mclk);
    latch <= 1'b1;
    wr_reg(`ADDR_UNIT_CTRL, 8'h00);
    repeat (2) @(negedge mclk);
    chk("pin_latch", pin, 1'b1);
    wr_reg(`ADDR_CMP_LO, 8'hc0);
    wr_reg(`ADDR_UNIT_CTRL, {4'h0, `MODE_TOGGLE});
    repeat (2) @(negedge mclk);
    chk("pin_zero", pin, 1'b0);
    wait_hi(pin);
    chk("pin_tgl", pin, 1'b1);
    wr_reg(`ADDR_EVT_STATUS, 8'h00);
    wr_reg(`ADDR_CMP_LO, 8'hf0);
    wr_reg(`ADDR_UNIT_CTRL, {4'h0, `MODE_CMP_FLAG});
    repeat (64) @(negedge mclk);
    rd_reg(`ADDR_EVT_STATUS, v);
    chk("flag_only", {v[0], pin, ra}, 3'b110);
  endtask
  // pin pulses of three cycles; t_cap is the timebase value a capture takes
  task automatic cap_pulse(int n);
    repeat (n) begin
      @(posedge mclk);
      cap <= 1'b1;
      @(negedge mclk);
      t_cap = ta + 16'h0002;
      repeat (3) @(posedge mclk);
      cap <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
  task automatic t_capture();
    wr_reg(`ADDR_UNIT_CTRL, {4'h0, `MODE_CAP_RISE});
    wr_reg(`ADDR_EVT_STATUS, 8'h00);
    cap_pulse(1);
    rd_reg(`ADDR_CMP_LO, v);
    chk("cap_lo", v, t_cap[7:0]);
    wr_reg(`ADDR_UNIT_CTRL, {4'h0, `MODE_CAP_RISE4});
    cap_pulse(2);
    wr_reg(`ADDR_UNIT_CTRL, 8'h00);
    wr_reg(`ADDR_UNIT_CTRL, {4'h0, `MODE_CAP_RISE4});
    wr_reg(`ADDR_EVT_STATUS, 8'h00);
    cap_pulse(2);
    rd_reg(`ADDR_EVT_STATUS, v);
    chk("presc_clr", v, 8'h00);
    // a direct switch keeps the count of two, so two more edges capture
    wr_reg(`ADDR_UNIT_CTRL, {4'h0, `MODE_CAP_RISE16});
    wr_reg(`ADDR_UNIT_CTRL, {4'h0, `MODE_CAP_RISE4});
    cap_pulse(2);
    rd_reg(`ADDR_EVT_STATUS, v);
    chk("presc_keep", v, 8'h01);
    wr_reg(`ADDR_EVT_STATUS, 8'h03);
    repeat (2) @(negedge mclk);
    chk("irq", irq, 1'b1);
    wr_reg(`ADDR_EVT_STATUS, 8'h00);
    wr_reg(`ADDR_TB_SEL, 8'h01);
    t_cap = tb + 16'h0040;
    wr_reg(`ADDR_CMP_LO, t_cap[7:0]);
    wr_reg(`ADDR_CMP_HI, t_cap[15:8]);
    wr_reg(`ADDR_UNIT_CTRL, {4'h0, `MODE_CMP_TRIG});
    wait_hi(rb);
    chk("rb", {ra, rb}, 2'b01);
  endtask
  task automatic t_shutdown();
    wr_reg(`ADDR_ASD_CTRL, 8'h44);
    fault <= 1'b0;
    repeat (4) @(negedge mclk);
    chk("ac", {oa, oc, na, nc}, 4'hc);
    chk("bd", {ob, od, nb, nd}, 4'h0);
    rd_reg(`ADDR_ASD_CTRL, v);
    chk("status", v, 8'hc4);
    @(posedge mclk);
    en <= 4'he;
    @(negedge mclk);
    chk("pin_off", {oa, na}, 2'b01);
    @(posedge mclk);
    en <= 4'hf;
    wr_reg(`ADDR_ASD_CTRL, 8'h4a);
    rd_reg(`ADDR_ASD_CTRL, v);
    chk("held", v, 8'hca);
    chk("tri", {na, nb, nc, nd}, 4'hf);
    @(posedge mclk);
    fault <= 1'b1;
    repeat (4) @(negedge mclk);
    wr_reg(`ADDR_ASD_CTRL, 8'h4a);
    // second negedge: state has left shut and waits for a period start
    repeat (2) @(negedge mclk);
    chk("wait", {na, nb}, 2'b11);
    wait_hi(ps);
    repeat (2) @(negedge mclk);
    chk("run", {oa, ob, na, nb}, {ta[0], ta[1], 2'b00});
    wr_reg(`ADDR_RESTART, 8'h01);
    fault <= 1'b0;
    repeat (4) @(posedge mclk);
    fault <= 1'b1;
    repeat (4) @(negedge mclk);
    rd_reg(`ADDR_ASD_CTRL, v);
    chk("auto", v, 8'h4a);
  endtask
  initial begin
    {rst_n, wr, rd, cap, latch, c1, c2} = '0;
    {fault, adc_en} = 2'b11;
    addr = 12'h000;
    wd = 8'h00;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg(12'h123, v);
    chk("unmapped", v, 8'h00);
    rd_reg(`ADDR_ASD_CTRL, v);
    chk("asd_rst", v, 8'h00);
    t_compare();
    t_capture();
    t_shutdown();
    end_sim();
  end
  // watchdog well beyond the longest compare period waits
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    end_sim();
  end
endmodule
